// ===== hdl/eipc_pkg.sv
// Package for the external interrupt pin controller.
// Assumes a single 8-bit status/control register on a plain strobe port.
package eipc_pkg;

    // Register map
    localparam logic [1:0] EIPC_ADDR_STATUS_CONTROL = 2'h0;

    // Field positions of the status/control register
    localparam int EIPC_BIT_PULL_DISABLE     = 6;
    localparam int EIPC_BIT_POLARITY_SELECT  = 5;
    localparam int EIPC_BIT_PIN_ENABLE       = 4;
    localparam int EIPC_BIT_EVENT_FLAG       = 3;
    localparam int EIPC_BIT_EVENT_ACK        = 2;
    localparam int EIPC_BIT_INTERRUPT_ENABLE = 1;
    localparam int EIPC_BIT_DETECTION_MODE   = 0;

    // Reset values
    localparam logic [7:0] EIPC_RESET_VALUE = 8'h00;
    localparam logic       EIPC_PIN_RESET   = 1'b1;

    // Control fields carried as one bundle
    typedef struct packed {
        logic pull_disable;
        logic polarity_select;
        logic pin_function_enable;
        logic interrupt_enable;
        logic detection_mode;
    } eipc_ctrl_t;

    // Pull device request to the pad
    typedef struct packed {
        logic pull_up_en;
        logic pull_down_en;
    } eipc_pull_t;

endpackage

// ===== hdl/eipc_top.sv
// External interrupt pin controller: pin sync, edge/level detect, flag, pull control.
// Assumes the pin input is synchronous-safe after two flops and a 100 MHz clk.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R1: With the pin enabled, pull_disable set turns off the internal pull device.
// R2: polarity_select zero picks falling/low detection, one picks rising/high detection.
// R3: With the pin enabled the pull is a pull-down for rising and a pull-up for falling.
// R4: pin_function_enable makes the pin an interrupt input, otherwise the function is off.
// R5: event_flag is read-only and is set by each qualifying edge or level event.
// R6: Writing one to event_acknowledge clears event_flag, subject to level mode.
// R7: Writing zero to event_acknowledge does nothing and the bit always reads zero.
// R8: In edge-and-level mode the flag stays set while the pin holds its asserted level.
// R9: With interrupt_enable set the interrupt request follows event_flag.
// R10: detection_mode zero detects edges only, one also detects asserted levels.
// R11: A disabled pin never sets the flag, and bit 7 reads zero and ignores writes.
// R12: The pin is synchronised and edges found by comparing successive samples.
module eipc_top (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic [1:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic [7:0]             reg_rdata,
    input  wire logic              irq_pin,
    output eipc_pkg::eipc_pull_t   pull_ctrl,
    output logic                   irq_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    eipc_pkg::eipc_ctrl_t ctrl_q;
    eipc_pkg::eipc_ctrl_t ctrl_d;
    logic                 flag_q;
    logic                 flag_d;
    logic                 sync1_q;
    logic                 sync2_q;
    logic                 prev_q;
    logic [7:0]           rdata_q;
    logic [7:0]           rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    // Address hits and strobes
    wire hit       = (reg_addr == eipc_pkg::EIPC_ADDR_STATUS_CONTROL);
    wire wr_hit    = reg_write & hit;
    wire rd_hit    = reg_read & hit;
    wire ack_write = wr_hit & reg_wdata[eipc_pkg::EIPC_BIT_EVENT_ACK]; // R6 R7

    // Next control value; bit 7 and the flag/ack bits are not stored
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_hit) begin
            ctrl_d.pull_disable        = reg_wdata[eipc_pkg::EIPC_BIT_PULL_DISABLE];
            ctrl_d.polarity_select     = reg_wdata[eipc_pkg::EIPC_BIT_POLARITY_SELECT];
            ctrl_d.pin_function_enable = reg_wdata[eipc_pkg::EIPC_BIT_PIN_ENABLE];
            ctrl_d.interrupt_enable    = reg_wdata[eipc_pkg::EIPC_BIT_INTERRUPT_ENABLE];
            ctrl_d.detection_mode      = reg_wdata[eipc_pkg::EIPC_BIT_DETECTION_MODE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and detection

    // Sample seen as asserted level for the chosen polarity
    function automatic logic asserted_level(input logic sample, input logic rising);
        return rising ? sample : ~sample;
    endfunction

    // Pin level normalised so that one means asserted
    wire pin_now   = asserted_level(sync2_q, ctrl_q.polarity_select); // R2
    wire pin_prev  = asserted_level(prev_q, ctrl_q.polarity_select);  // R2
    wire edge_seen = pin_now & ~pin_prev;                // R12
    wire level_on  = ctrl_q.detection_mode & pin_now;    // R10 R8
    wire event_hit = ctrl_q.pin_function_enable & (edge_seen | level_on); // R4 R11 R5

    // Set wins over acknowledge, so a held level keeps the flag
    assign flag_d = event_hit | (flag_q & ~ack_write); // R5 R6 R8

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Unmapped addresses read zero; bit 7 and ack read zero
    always_comb begin
        rdata_d = 8'h00;
        if (rd_hit) begin
            rdata_d[eipc_pkg::EIPC_BIT_PULL_DISABLE]     = ctrl_q.pull_disable;
            rdata_d[eipc_pkg::EIPC_BIT_POLARITY_SELECT]  = ctrl_q.polarity_select;
            rdata_d[eipc_pkg::EIPC_BIT_PIN_ENABLE]       = ctrl_q.pin_function_enable;
            rdata_d[eipc_pkg::EIPC_BIT_EVENT_FLAG]       = flag_q;
            rdata_d[eipc_pkg::EIPC_BIT_INTERRUPT_ENABLE] = ctrl_q.interrupt_enable;
            rdata_d[eipc_pkg::EIPC_BIT_DETECTION_MODE]   = ctrl_q.detection_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Control, flag and read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q  <= eipc_pkg::eipc_ctrl_t'(5'h00);
            flag_q  <= 1'b0;
            rdata_q <= eipc_pkg::EIPC_RESET_VALUE;
        end else if (clk_en) begin
            ctrl_q  <= ctrl_d;
            flag_q  <= flag_d;
            rdata_q <= rdata_d;
        end
    end

    // Two-flop synchroniser plus previous sample
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_q <= eipc_pkg::EIPC_PIN_RESET;
            sync2_q <= eipc_pkg::EIPC_PIN_RESET;
            prev_q  <= eipc_pkg::EIPC_PIN_RESET;
        end else if (clk_en) begin
            sync1_q <= irq_pin;  // R12
            sync2_q <= sync1_q;  // R12
            prev_q  <= sync2_q;  // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Pull follows polarity while enabled and not disabled
    wire pull_on = ctrl_q.pin_function_enable & ~ctrl_q.pull_disable; // R1 R4
    assign pull_ctrl.pull_up_en   = pull_on & ~ctrl_q.polarity_select; // R3
    assign pull_ctrl.pull_down_en = pull_on & ctrl_q.polarity_select;  // R3
    assign irq_request = flag_q & ctrl_q.interrupt_enable;             // R9
    assign reg_rdata   = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Enabled cycles since reset, saturating, gates history checks
    logic [1:0] settle_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settle_q <= 2'h0;
        end else if (clk_en && (settle_q != 2'h3)) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pull device checks

    // Disabled pull drives neither way
    AST_PULL_OFF: assert property ( // R1
            ctrl_q.pull_disable |-> !pull_ctrl.pull_up_en && !pull_ctrl.pull_down_en)
        else $error("pull active while disabled");

    // Pull direction follows polarity while enabled
    AST_PULL_DIR: assert property ( // R3
            pull_on |-> pull_ctrl.pull_up_en == !ctrl_q.polarity_select
            && pull_ctrl.pull_down_en == ctrl_q.polarity_select)
        else $error("pull direction wrong");

    // Never both pull devices at once
    AST_PULL_ONE: assert property ( // R3
            !(pull_ctrl.pull_up_en && pull_ctrl.pull_down_en))
        else $error("both pulls active");

    // Pin function off means no pull at all
    AST_PULL_PE: assert property ( // R4
            !ctrl_q.pin_function_enable |-> !pull_ctrl.pull_up_en && !pull_ctrl.pull_down_en)
        else $error("pull active with pin off");

    ////////////////////////////////////////////////////////////////////////////
    // Register write checks

    // Written pull disable lands
    AST_WR_PD: assert property ( // R1
            clk_en && wr_hit
            |=> ctrl_q.pull_disable == $past(reg_wdata[eipc_pkg::EIPC_BIT_PULL_DISABLE]))
        else $error("pull disable not stored");

    // Written polarity lands
    AST_WR_POL: assert property ( // R2
            clk_en && wr_hit
            |=> ctrl_q.polarity_select == $past(reg_wdata[eipc_pkg::EIPC_BIT_POLARITY_SELECT]))
        else $error("polarity not stored");

    // Written pin enable lands
    AST_WR_PE: assert property ( // R4
            clk_en && wr_hit
            |=> ctrl_q.pin_function_enable == $past(reg_wdata[eipc_pkg::EIPC_BIT_PIN_ENABLE]))
        else $error("pin enable not stored");

    // Written interrupt enable lands
    AST_WR_IE: assert property ( // R9
            clk_en && wr_hit
            |=> ctrl_q.interrupt_enable
                == $past(reg_wdata[eipc_pkg::EIPC_BIT_INTERRUPT_ENABLE]))
        else $error("interrupt enable not stored");

    // Written detection mode lands
    AST_WR_MODE: assert property ( // R10
            clk_en && wr_hit
            |=> ctrl_q.detection_mode == $past(reg_wdata[eipc_pkg::EIPC_BIT_DETECTION_MODE]))
        else $error("detection mode not stored");

    // Unmapped writes leave the control alone
    AST_WR_UNMAPPED: assert property ( // R11
            clk_en && reg_write && !hit |=> ctrl_q == $past(ctrl_q))
        else $error("unmapped write changed control");

    ////////////////////////////////////////////////////////////////////////////
    // Register read checks

    // Flag bit reads the stored flag
    AST_FLAG_RD: assert property ( // R5
            rd_hit && clk_en |=> reg_rdata[eipc_pkg::EIPC_BIT_EVENT_FLAG] == $past(flag_q))
        else $error("flag read mismatch");

    // Control bits read back as stored
    AST_RD_CTRL: assert property ( // R4
            rd_hit && clk_en
            |=> reg_rdata[eipc_pkg::EIPC_BIT_PULL_DISABLE] == $past(ctrl_q.pull_disable)
            && reg_rdata[eipc_pkg::EIPC_BIT_POLARITY_SELECT] == $past(ctrl_q.polarity_select)
            && reg_rdata[eipc_pkg::EIPC_BIT_PIN_ENABLE] == $past(ctrl_q.pin_function_enable)
            && reg_rdata[eipc_pkg::EIPC_BIT_INTERRUPT_ENABLE]
                == $past(ctrl_q.interrupt_enable)
            && reg_rdata[eipc_pkg::EIPC_BIT_DETECTION_MODE] == $past(ctrl_q.detection_mode))
        else $error("control read mismatch");

    // Acknowledge bit always reads zero
    AST_ACK_RD0: assert property ( // R7
            clk_en && rd_hit |=> !reg_rdata[eipc_pkg::EIPC_BIT_EVENT_ACK])
        else $error("write-only bit read high");

    // Top bit always reads zero
    AST_BIT7: assert property ( // R11
            clk_en && rd_hit |=> !reg_rdata[7])
        else $error("bit 7 read high");

    // Read data is zero outside the answer cycle
    AST_RD_IDLE: assert property ( // R11
            clk_en && !rd_hit |=> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Event flag checks

    // Falling edge sets the flag
    AST_POLARITY: assert property ( // R2
            clk_en && ctrl_q.pin_function_enable && !ctrl_q.polarity_select
            && prev_q && !sync2_q |=> flag_q)
        else $error("falling edge missed");

    // Rising edge sets the flag
    AST_RISING: assert property ( // R2
            clk_en && ctrl_q.pin_function_enable && ctrl_q.polarity_select
            && !prev_q && sync2_q |=> flag_q)
        else $error("rising edge missed");

    // Disabled pin never raises the flag
    AST_DISABLED: assert property ( // R4
            clk_en && !ctrl_q.pin_function_enable && !flag_q |=> !flag_q)
        else $error("flag set with pin off");

    // Flag never rises without an event
    AST_NO_SPURIOUS: assert property ( // R5
            clk_en && !event_hit && !flag_q |=> !flag_q)
        else $error("flag set without event");

    // Acknowledge with no event clears
    AST_ACK_CLR: assert property ( // R6
            clk_en && ack_write && !event_hit |=> !flag_q)
        else $error("ack did not clear");

    // Write with acknowledge zero keeps the flag
    AST_ACK_ZERO: assert property ( // R7
            clk_en && wr_hit && !reg_wdata[eipc_pkg::EIPC_BIT_EVENT_ACK] && flag_q
            |=> flag_q)
        else $error("zero ack cleared flag");

    // Held level keeps the flag despite acknowledge
    AST_LEVEL_HOLD: assert property ( // R8
            clk_en && ctrl_q.pin_function_enable && ctrl_q.detection_mode && pin_now
            |=> flag_q)
        else $error("level flag cleared");

    // Edge-only mode lets acknowledge clear a held level
    AST_EDGE_ONLY: assert property ( // R10
            clk_en && !ctrl_q.detection_mode && !edge_seen && ack_write |=> !flag_q)
        else $error("level set flag in edge mode");

    ////////////////////////////////////////////////////////////////////////////
    // Request, synchroniser and freeze checks

    // Request rises after a stored flag with enable
    AST_IRQ: assert property ( // R9
            clk_en && flag_d && ctrl_d.interrupt_enable |=> irq_request)
        else $error("irq request missing");

    // No request while interrupt enable is low
    AST_IRQ_OFF: assert property ( // R9
            !ctrl_q.interrupt_enable |-> !irq_request)
        else $error("irq request while disabled");

    // Second stage shows the pin two enabled edges late
    AST_SYNC: assert property ( // R12
            (settle_q == 2'h3) && clk_en && $past(clk_en) && $past(clk_en, 2)
            |-> sync2_q == $past(irq_pin, 2))
        else $error("sync delay wrong");

    // Low enable freezes flag, synchroniser and read data
    AST_FREEZE: assert property ( // R12
            !clk_en |=> $stable(flag_q) && $stable(sync2_q) && $stable(reg_rdata))
        else $error("state moved while frozen");

    COV_EDGE:   cover property (edge_seen && ctrl_q.pin_function_enable);
    COV_LEVEL:  cover property (ack_write && level_on ##1 flag_q);
    COV_IRQ:    cover property (irq_request ##1 ack_write ##1 !irq_request);
    COV_RISE:   cover property (clk_en && ctrl_q.polarity_select && edge_seen);
    COV_FREEZE: cover property (!clk_en ##1 clk_en);

endmodule

`default_nettype wire

// ===== sim/eipc_pin_model.sv
// Far-side device that drives the interrupt pin, with the pad pull.
// Assumes pull_ctrl comes from the controller; undriven, unpulled pin wanders.
`timescale 1ns/10ps
`default_nettype none
module eipc_pin_model (
    input  wire logic          clk,
    input  wire logic          drive_en,
    input  wire logic          drive_val,
    input  wire eipc_pkg::eipc_pull_t pull_ctrl,
    output logic               pin
);
    logic last_q;
    // Released pin follows the pull, else the inverse of its last level
    assign pin = drive_en ? drive_val : pull_ctrl.pull_up_en ? 1'b1 :
                 pull_ctrl.pull_down_en ? 1'b0 : ~last_q;
    always_ff @(posedge clk) begin
        last_q <= pin;
    end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the external interrupt pin controller.
// Assumes one register at address 0 and a pin model on the far side.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic drv_en = 1'b1, drv_val = 1'b1, irq_pin, irq_request, clk_en = 1'b1;
    eipc_pkg::eipc_pull_t pull_ctrl;
    int error_cnt = 0, checked = 0, cycles = 0;
    always #5 clk = ~clk;
    eipc_top dut (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq_pin(irq_pin), .pull_ctrl(pull_ctrl),
        .irq_request(irq_request));
    eipc_pin_model pin_dev (.clk(clk), .drive_en(drv_en), .drive_val(drv_val),
        .pull_ctrl(pull_ctrl), .pin(irq_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk) begin reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d; end
        @(posedge clk) reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk) begin reg_read <= 1'b1; reg_addr <= a; end
        @(posedge clk) reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic pin_to(input logic v);
        @(posedge clk) drv_val <= v;
        repeat (6) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset value, write-only and read-only bits, unmapped address
    task automatic t_regs();
        rd(2'h0, 8'h00);
        pin_to(1'b0);
        wr(2'h0, 8'hFF);
        rd(2'h0, 8'h73);
        chk({6'h0, pull_ctrl}, 8'h00);
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h0, 8'h73);
    endtask
    // Pull device follows polarity and enable
    task automatic t_pull();
        wr(2'h0, 8'h10);
        #1 chk({6'h0, pull_ctrl}, 8'h02);
        @(posedge clk) drv_en <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, irq_pin}, 8'h01);
        wr(2'h0, 8'h30);
        #1 chk({6'h0, pull_ctrl}, 8'h01);
        chk({7'h0, irq_pin}, 8'h00);
        repeat (4) @(posedge clk);
        drv_en <= 1'b1;
        wr(2'h0, 8'h00);
        #1 chk({6'h0, pull_ctrl}, 8'h00);
    endtask
    // Falling edge, zero ack ignored, one ack clears, then no request with ie low
    task automatic t_edge();
        pin_to(1'b1);
        wr(2'h0, 8'h12);
        pin_to(1'b0);
        chk({7'h0, irq_request}, 8'h01);
        wr(2'h0, 8'h12);
        rd(2'h0, 8'h1A);
        wr(2'h0, 8'h16);
        rd(2'h0, 8'h12);
        chk({7'h0, irq_request}, 8'h00);
        pin_to(1'b1);
        wr(2'h0, 8'h10);
        pin_to(1'b0);
        rd(2'h0, 8'h18);
        chk({7'h0, irq_request}, 8'h00);
    endtask
    // Level mode keeps the flag while asserted
    task automatic t_level();
        wr(2'h0, 8'h13);
        wr(2'h0, 8'h17);
        rd(2'h0, 8'h1B);
        pin_to(1'b1);
        wr(2'h0, 8'h17);
        rd(2'h0, 8'h13);
    endtask
    // Rising polarity keeps the earlier falling-level flag until ack, then takes rising edge
    task automatic t_rise();
        pin_to(1'b0);
        wr(2'h0, 8'h36);
        rd(2'h0, 8'h3A);
        wr(2'h0, 8'h36);
        rd(2'h0, 8'h32);
        pin_to(1'b1);
        rd(2'h0, 8'h3A);
    endtask
    // Disabled pin never flags
    task automatic t_off();
        wr(2'h0, 8'h06);
        pin_to(1'b0);
        pin_to(1'b1);
        rd(2'h0, 8'h02);
        chk({7'h0, irq_request}, 8'h00);
    endtask
    // Low clock enable freezes detection and ignores writes
    task automatic t_freeze();
        wr(2'h0, 8'h12);
        @(posedge clk) clk_en <= 1'b0;
        pin_to(1'b0);
        chk({7'h0, irq_request}, 8'h00);
        wr(2'h0, 8'h00);
        @(posedge clk) clk_en <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk({7'h0, irq_request}, 8'h01);
        rd(2'h0, 8'h1A);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_pull();
        t_edge();
        t_level();
        t_rise();
        t_off();
        t_freeze();
        give_verdict();
    end
endmodule
`default_nettype wire
